// >>> verilog/submap_pkg.sv
// constants of the user sub map register bank
package submap_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int ULPS_ENTRY_NS = 1000;
	localparam int ULPS_EXIT_NS = 1000;
	localparam int ENTRY_CYC = (ULPS_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EXIT_CYC = (ULPS_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------
	// bus addresses and identity
	// ----------------------------------------
	localparam logic [6:0] USER_ADDR_DEF = 7'h20;
	// arbitrary identification value
	localparam logic [7:0] IDENT_DEF = 8'h5a;

	// ----------------------------------------
	// read-only and special offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_LOCK_STATUS_ONE = 8'h10;
	localparam logic [7:0] OFS_DEVICE_IDENT = 8'h11;
	localparam logic [7:0] OFS_SIGNAL_STATUS_TWO = 8'h12;
	localparam logic [7:0] OFS_SIGNAL_STATUS_THREE = 8'h13;
	localparam logic [7:0] OFS_SUBMAP_CONTROL = 8'h0e;
	localparam logic [7:0] OFS_ESCAPE_CONTROL = 8'h26;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int SUBMAP_SEL_LSB = 5;
	localparam int ESC_ENABLE_BIT = 5;
	localparam int ESC_RELEASE_BIT = 4;
	localparam logic [1:0] SUBMAP_USER = 2'b00;

	// ----------------------------------------
	// read/write register table
	// ----------------------------------------
	localparam int RW_COUNT = 25;
	localparam int IDX_SUBMAP = 11;
	localparam int IDX_ESC = 19;
	localparam int IDX_PP_ADDR = 23;
	localparam int IDX_TX_ADDR = 24;
	localparam logic [7:0] RW_OFS [RW_COUNT] = '{
		8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h07, 8'h08, 8'h0a, 8'h0b,
		8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h14, 8'h15, 8'h17, 8'h18, 8'h19,
		8'h1d, 8'h26, 8'h27, 8'h2b, 8'h2c, 8'hfd, 8'hfe};
	localparam logic [7:0] RW_RST [RW_COUNT] = '{
		8'h0e, 8'hc8, 8'h04, 8'h4c, 8'h35, 8'h7f, 8'h80, 8'h00, 8'h00,
		8'h36, 8'h7c, 8'h00, 8'h20, 8'h10, 8'h00, 8'h01, 8'h93, 8'hf1,
		8'hc0, 8'h00, 8'h58, 8'he1, 8'hae, 8'h00, 8'h00};
	localparam logic [7:0] RW_MASK [RW_COUNT] = '{
		8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
		8'hff, 8'hff, 8'h60, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
		8'hff, 8'hf0, 8'hff, 8'hff, 8'hff, 8'hfe, 8'hfe};

	// ----------------------------------------
	// state encodings
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_ADDR_ACK = 3'b010,
		ST_PTR = 3'b011,
		ST_WDATA = 3'b100,
		ST_DATA_ACK = 3'b101,
		ST_RDATA = 3'b110,
		ST_RD_ACK = 3'b111
	} bus_state_t;

	typedef enum logic [1:0] {
		TGT_USER = 2'b00,
		TGT_PP = 2'b01,
		TGT_TX = 2'b10
	} target_t;

	typedef enum logic [2:0] {
		LN_NORMAL = 3'b000,
		LN_ENTRY = 3'b001,
		LN_ULPS = 3'b010,
		LN_EXIT = 3'b011,
		LN_MARK = 3'b100
	} lane_state_t;

endpackage

// >>> verilog/lane_ctrl_if.sv
// register side to clock lane controller link
`timescale 1ns/10ps
interface lane_ctrl_if;
	logic esc_enable;
	logic shutdown_release;
	logic ctrl_wr;
	logic in_ulps;

	modport regs (output esc_enable, output shutdown_release, output ctrl_wr, input in_ulps);
	modport lane (input esc_enable, input shutdown_release, input ctrl_wr, output in_ulps);
endinterface

// >>> verilog/clock_lane_escape.sv
// clock lane ultralow power entry and exit sequencer
`timescale 1ns/10ps
module clock_lane_escape
	import submap_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// register side
	lane_ctrl_if.lane ctrl,
	// lane pins
	output logic clock_lane_pos,
	output logic clock_lane_neg,
	output logic clock_lane_normal
);

	lane_state_t state_reg;
	logic [7:0] seq_cnt_reg;
	logic wr_10;
	logic wr_11;
	logic wr_01;

	assign wr_10 = ctrl.ctrl_wr && ctrl.esc_enable && !ctrl.shutdown_release;
	assign wr_11 = ctrl.ctrl_wr && ctrl.esc_enable && ctrl.shutdown_release;
	assign wr_01 = ctrl.ctrl_wr && !ctrl.esc_enable && ctrl.shutdown_release;
	assign ctrl.in_ulps = (state_reg == LN_ULPS);

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_reg <= LN_NORMAL;
			seq_cnt_reg <= 8'h00;
		end else begin
			case (state_reg)
				LN_NORMAL: begin
					if (wr_10) begin
						state_reg <= LN_ENTRY;
						seq_cnt_reg <= 8'(ENTRY_CYC - 1);
					end
				end
				LN_ENTRY: begin
					if (seq_cnt_reg == 8'h00) begin
						state_reg <= LN_ULPS;
					end else begin
						seq_cnt_reg <= seq_cnt_reg - 8'h01;
					end
				end
				LN_ULPS: begin
					if (wr_11) begin
						state_reg <= LN_EXIT;
						seq_cnt_reg <= 8'(EXIT_CYC - 1);
					end
				end
				LN_EXIT: begin
					if (seq_cnt_reg == 8'h00) begin
						state_reg <= LN_MARK;
					end else begin
						seq_cnt_reg <= seq_cnt_reg - 8'h01;
					end
				end
				LN_MARK: begin
					if (wr_01) begin
						state_reg <= LN_NORMAL;
					end
				end
				default: begin
					state_reg <= LN_NORMAL;
				end
			endcase
		end
	end

	// ----------------------------------------
	// lane levels
	// ----------------------------------------
	// normal ignores 0,0
	always_ff @(posedge core_clk) begin
		if (srst) begin
			clock_lane_pos <= 1'b1;
			clock_lane_neg <= 1'b1;
			clock_lane_normal <= 1'b1;
		end else begin
			clock_lane_pos <= (state_reg != LN_ULPS);
			clock_lane_neg <= (state_reg == LN_NORMAL) || (state_reg == LN_MARK);
			clock_lane_normal <= (state_reg == LN_NORMAL);
		end
	end

endmodule

// >>> verilog/video_decoder_user_submap_regs.sv
// serial bus slave and user sub map register bank
`timescale 1ns/10ps
module video_decoder_user_submap_regs
	import submap_pkg::*;
#(
	parameter logic [6:0] USER_MAP_ADDR = USER_ADDR_DEF,
	parameter logic [7:0] IDENT_VALUE = IDENT_DEF
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// serial bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// decoder status
	input wire logic [7:0] lock_status_in,
	input wire logic [7:0] signal_status_two_in,
	input wire logic [7:0] signal_status_three_in,
	// secondary map access
	output logic sec_map_sel,
	output logic sec_wr_stb,
	output logic sec_rd_stb,
	output logic [7:0] sec_offset,
	output logic [7:0] sec_wdata,
	input wire logic [7:0] sec_rdata,
	// clock lane pins
	output logic clock_lane_pos,
	output logic clock_lane_neg,
	output logic clock_lane_normal,
	// selected sub map
	output logic [1:0] submap_select
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic [2:0] scl_sync_reg;
	logic [2:0] sda_sync_reg;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	bus_state_t state_reg;
	target_t tgt_reg;
	target_t tgt_next;
	logic [7:0] shift_reg;
	logic [7:0] tx_byte_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] ptr_reg;
	logic rw_reg;
	logic mack_reg;
	logic sda_oe_reg;
	logic addr_hit;
	logic byte_done;
	logic user_open;
	logic user_wr;
	logic load_byte;
	logic esc_wr_reg;
	logic [7:0] regs_reg [RW_COUNT];
	logic [RW_COUNT-1:0] hit;
	logic [7:0] rw_rdata;
	logic [7:0] user_rdata;
	logic [7:0] rd_data;
	logic [6:0] pp_addr;
	logic [6:0] tx_addr;
	lane_ctrl_if lane_if ();

	// ----------------------------------------
	// pin synchronisers and bus events
	// ----------------------------------------
	// stage 0 only feeds stage 1; events use stages 1 and 2
	always_ff @(posedge core_clk) begin
		if (srst) begin
			scl_sync_reg <= 3'b111;
			sda_sync_reg <= 3'b111;
		end else begin
			scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
			sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
		end
	end

	assign scl_rise = scl_sync_reg[1] && !scl_sync_reg[2];
	assign scl_fall = !scl_sync_reg[1] && scl_sync_reg[2];
	assign bus_start = scl_sync_reg[1] && scl_sync_reg[2] && !sda_sync_reg[1] && sda_sync_reg[2];
	assign bus_stop = scl_sync_reg[1] && scl_sync_reg[2] && sda_sync_reg[1] && !sda_sync_reg[2];

	// ----------------------------------------
	// address match
	// ----------------------------------------
	assign pp_addr = regs_reg[IDX_PP_ADDR][7:1];
	assign tx_addr = regs_reg[IDX_TX_ADDR][7:1];

	always_comb begin
		addr_hit = 1'b0;
		tgt_next = TGT_USER;
		if (shift_reg[7:1] == USER_MAP_ADDR) begin
			addr_hit = 1'b1;
		end else if (pp_addr != 7'h00 && shift_reg[7:1] == pp_addr) begin
			addr_hit = 1'b1;
			tgt_next = TGT_PP;
		end else if (tx_addr != 7'h00 && shift_reg[7:1] == tx_addr) begin
			addr_hit = 1'b1;
			tgt_next = TGT_TX;
		end
	end

	assign byte_done = scl_fall && (bit_cnt_reg == 4'h8);
	assign submap_select = regs_reg[IDX_SUBMAP][SUBMAP_SEL_LSB +: 2];
	// user map only with select 00
	assign user_open = (submap_select == SUBMAP_USER);
	// select register stays writable so software can return to 00
	assign user_wr = (state_reg == ST_WDATA) && byte_done && (tgt_reg == TGT_USER)
		&& (user_open || ptr_reg == OFS_SUBMAP_CONTROL);
	assign load_byte = scl_fall && ((state_reg == ST_ADDR_ACK && rw_reg)
		|| (state_reg == ST_RD_ACK && mack_reg));

	// ----------------------------------------
	// bus state machine
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_reg <= ST_IDLE;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			rw_reg <= 1'b0;
			mack_reg <= 1'b0;
		end else if (bus_stop) begin
			state_reg <= ST_IDLE;
		end else if (bus_start) begin
			state_reg <= ST_ADDR;
			bit_cnt_reg <= 4'h0;
		end else begin
			case (state_reg)
				ST_ADDR, ST_PTR, ST_WDATA: begin
					if (scl_rise) begin
						shift_reg <= {shift_reg[6:0], sda_sync_reg[1]};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end else if (byte_done) begin
						bit_cnt_reg <= 4'h0;
						if (state_reg != ST_ADDR) begin
							state_reg <= ST_DATA_ACK;
						end else if (addr_hit) begin
							state_reg <= ST_ADDR_ACK;
							rw_reg <= shift_reg[0];
						end else begin
							state_reg <= ST_IDLE;
						end
					end
				end
				ST_ADDR_ACK: begin
					if (scl_fall) begin
						state_reg <= rw_reg ? ST_RDATA : ST_PTR;
					end
				end
				ST_DATA_ACK: begin
					if (scl_fall) begin
						state_reg <= ST_WDATA;
					end
				end
				ST_RDATA: begin
					if (scl_fall) begin
						if (bit_cnt_reg == 4'h7) begin
							state_reg <= ST_RD_ACK;
							bit_cnt_reg <= 4'h0;
						end else begin
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end
					end
				end
				ST_RD_ACK: begin
					if (scl_rise) begin
						mack_reg <= !sda_sync_reg[1];
					end else if (scl_fall) begin
						state_reg <= mack_reg ? ST_RDATA : ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// target and pointer
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst) begin
			tgt_reg <= TGT_USER;
			ptr_reg <= 8'h00;
		end else begin
			if (state_reg == ST_ADDR && byte_done && addr_hit) begin
				tgt_reg <= tgt_next;
			end
			if (state_reg == ST_PTR && byte_done) begin
				ptr_reg <= shift_reg;
			end else if ((state_reg == ST_WDATA && byte_done) || load_byte) begin
				// auto increment across a burst
				ptr_reg <= ptr_reg + 8'h01;
			end
		end
	end

	// ----------------------------------------
	// sda drive, open drain
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst) begin
			sda_oe_reg <= 1'b0;
			tx_byte_reg <= 8'h00;
		end else if (bus_start || bus_stop) begin
			sda_oe_reg <= 1'b0;
		end else if (scl_fall) begin
			if (state_reg == ST_ADDR) begin
				sda_oe_reg <= byte_done && addr_hit;
			end else if (state_reg == ST_PTR || state_reg == ST_WDATA) begin
				sda_oe_reg <= byte_done;
			end else if (load_byte) begin
				tx_byte_reg <= {rd_data[6:0], 1'b0};
				sda_oe_reg <= !rd_data[7];
			end else if (state_reg == ST_RDATA && bit_cnt_reg != 4'h7) begin
				tx_byte_reg <= {tx_byte_reg[6:0], 1'b0};
				sda_oe_reg <= !tx_byte_reg[7];
			end else begin
				sda_oe_reg <= 1'b0;
			end
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe = sda_oe_reg;

	// ----------------------------------------
	// read/write register storage
	// ----------------------------------------
	for (genvar g = 0; g < RW_COUNT; g++) begin : g_reg
		assign hit[g] = (ptr_reg == RW_OFS[g]);
		always_ff @(posedge core_clk) begin
			if (srst) begin
				regs_reg[g] <= RW_RST[g];
			end else if (user_wr && hit[g]) begin
				regs_reg[g] <= shift_reg & RW_MASK[g];
			end
		end
	end

	// ----------------------------------------
	// read data
	// ----------------------------------------
	always_comb begin
		rw_rdata = 8'h00;
		for (int i = 0; i < RW_COUNT; i++) begin
			if (hit[i]) begin
				rw_rdata = regs_reg[i];
			end
		end
	end

	always_comb begin
		user_rdata = 8'h00;
		if (ptr_reg == OFS_LOCK_STATUS_ONE) begin
			user_rdata = lock_status_in;
		end else if (ptr_reg == OFS_DEVICE_IDENT) begin
			user_rdata = IDENT_VALUE;
		end else if (ptr_reg == OFS_SIGNAL_STATUS_TWO) begin
			user_rdata = signal_status_two_in & 8'h3f;
		end else if (ptr_reg == OFS_SIGNAL_STATUS_THREE) begin
			user_rdata = signal_status_three_in & 8'hf5;
		end else if (ptr_reg == OFS_ESCAPE_CONTROL && lane_if.in_ulps) begin
			// ulps reads enable 1, release 0
			user_rdata = rw_rdata;
			user_rdata[ESC_ENABLE_BIT] = 1'b1;
			user_rdata[ESC_RELEASE_BIT] = 1'b0;
		end else begin
			user_rdata = rw_rdata;
		end
	end

	always_comb begin
		rd_data = 8'h00;
		if (tgt_reg != TGT_USER) begin
			rd_data = sec_rdata;
		end else if (user_open || ptr_reg == OFS_SUBMAP_CONTROL) begin
			rd_data = user_rdata;
		end
	end

	// ----------------------------------------
	// secondary map strobes
	// ----------------------------------------
	// read data is taken on the edge that raises the read strobe, so it must be valid in the cycle before the strobe
	always_ff @(posedge core_clk) begin
		if (srst) begin
			sec_map_sel <= 1'b0;
			sec_wr_stb <= 1'b0;
			sec_rd_stb <= 1'b0;
			sec_offset <= 8'h00;
			sec_wdata <= 8'h00;
		end else begin
			sec_map_sel <= (tgt_reg == TGT_TX);
			sec_wr_stb <= (state_reg == ST_WDATA) && byte_done && (tgt_reg != TGT_USER);
			sec_rd_stb <= load_byte && (tgt_reg != TGT_USER);
			sec_offset <= ptr_reg;
			if (state_reg == ST_WDATA && byte_done) begin
				sec_wdata <= shift_reg;
			end
		end
	end

	// ----------------------------------------
	// clock lane escape control
	// ----------------------------------------
	// bits 5 and 4 of 0x26
	assign lane_if.esc_enable = regs_reg[IDX_ESC][ESC_ENABLE_BIT];
	assign lane_if.shutdown_release = regs_reg[IDX_ESC][ESC_RELEASE_BIT];
	assign lane_if.ctrl_wr = esc_wr_reg;

	// one cycle late so the lane sees the new field values
	always_ff @(posedge core_clk) begin
		if (srst) begin
			esc_wr_reg <= 1'b0;
		end else begin
			esc_wr_reg <= user_wr && hit[IDX_ESC];
		end
	end

	clock_lane_escape u_lane (
		.core_clk(core_clk),
		.srst(srst),
		.ctrl(lane_if.lane),
		.clock_lane_pos(clock_lane_pos),
		.clock_lane_neg(clock_lane_neg),
		.clock_lane_normal(clock_lane_normal)
	);

endmodule

// >>> verification/submap_props.sv
// concurrent checks on the user sub map block ports
`timescale 1ns/10ps
module submap_props (
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// serial bus and secondary map
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic sec_wr_stb,
	input wire logic sec_rd_stb,
	// lane and select outputs
	input wire logic clock_lane_pos,
	input wire logic clock_lane_neg,
	input wire logic clock_lane_normal,
	input wire logic [1:0] submap_select
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	// ----------------------------------------
	// lane sequences
	// ----------------------------------------
	// the tolerance of a few cycles covers the ten cycle entry and exit holds beyond the eight checked
	sequence s_entry;
		(clock_lane_pos && !clock_lane_neg)[*8] ##[1:4] (!clock_lane_pos && !clock_lane_neg);
	endsequence
	sequence s_exit;
		(clock_lane_pos && !clock_lane_neg && !clock_lane_normal)[*8]
			##[1:4] (clock_lane_pos && clock_lane_neg && !clock_lane_normal);
	endsequence
	a_entry_to_ulps: assert property ($fell(clock_lane_neg) && clock_lane_pos |-> s_entry)
		else $error("entry sequence not followed by low lanes");
	a_exit_to_high: assert property ($rose(clock_lane_pos) |-> s_exit)
		else $error("exit sequence not followed by high lanes");
	a_normal_lanes_high: assert property (clock_lane_normal |-> clock_lane_pos && clock_lane_neg)
		else $error("normal operation with a low lane");
	a_no_split_level: assert property (!(clock_lane_neg && !clock_lane_pos))
		else $error("negative lane high while positive low");
	// ----------------------------------------
	// bus side
	// ----------------------------------------
	a_open_drain_low: assert property (!sda_out)
		else $error("data pin driven high");
	// ack and the register update leave on the same edge
	a_select_on_ack: assert property ($changed(submap_select) |-> sda_oe)
		else $error("sub map select changed outside an acked byte");
	a_write_on_ack: assert property ($rose(sec_wr_stb) |-> sda_oe)
		else $error("secondary write without acknowledge");
	a_write_one_cycle: assert property (sec_wr_stb |=> !sec_wr_stb)
		else $error("secondary write strobe longer than one cycle");
	a_read_one_cycle: assert property (sec_rd_stb |-> !sec_wr_stb ##1 !sec_rd_stb)
		else $error("secondary read strobe malformed");
	// ack plus a zero read byte is the longest pull
	a_pin_released: assert property ($rose(sda_oe) |-> ##[1:100] !sda_oe)
		else $error("data pin held low too long");
endmodule

bind video_decoder_user_submap_regs submap_props u_props (
	.core_clk(core_clk),
	.srst(srst),
	.sda_out(sda_out),
	.sda_oe(sda_oe),
	.sec_wr_stb(sec_wr_stb),
	.sec_rd_stb(sec_rd_stb),
	.clock_lane_pos(clock_lane_pos),
	.clock_lane_neg(clock_lane_neg),
	.clock_lane_normal(clock_lane_normal),
	.submap_select(submap_select)
);

// >>> verification/i2c_host_model.sv
// serial bus host that configures the decoder
`timescale 1ns/10ps
module i2c_host_model (
	// bus pins
	output logic scl,
	output logic sda_pull,
	input wire logic sda
);
	// quarter of the 800 ns bus clock; clock stands high between frames
	localparam int QTR = 200;
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	task automatic bit_out(input logic b);
		sda_pull = !b;
		#QTR scl = 1'b1;
		#(2*QTR) scl = 1'b0;
		#QTR;
	endtask
	task automatic bit_in(output logic b);
		sda_pull = 1'b0;
		#QTR scl = 1'b1;
		#QTR b = sda;
		#QTR scl = 1'b0;
		#QTR;
	endtask
	task automatic start();
		sda_pull = 1'b0;
		#QTR scl = 1'b1;
		#QTR sda_pull = 1'b1;
		#QTR scl = 1'b0;
		#QTR;
	endtask
	task automatic stop();
		sda_pull = 1'b1;
		#QTR scl = 1'b1;
		#QTR sda_pull = 1'b0;
		#(2*QTR);
	endtask
	// msb first, ack sampled in the ninth slot
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			bit_out(d[i]);
		end
		bit_in(a);
		ack = !a;
	endtask
	task automatic rbyte(input logic last, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			bit_in(d[i]);
		end
		bit_out(last);
	endtask
endmodule

// >>> verification/tb_top.sv
// self-checking bench for the user sub map register bank
`timescale 1ns/10ps
module tb_top
	import submap_pkg::*;
;
	localparam logic [6:0] UA = USER_ADDR_DEF;
	localparam logic [6:0] PA = 7'b1000010;
	localparam logic [6:0] TA = 7'b1000100;
	logic core_clk;
	logic srst = 1'b1;
	logic scl, sda_pull, sda, sda_out, sda_oe, ack;
	logic sec_map_sel, sec_wr_stb, sec_rd_stb, wr_sel;
	logic [7:0] sec_offset, sec_wdata, wr_ofs, wr_dat, rd, exp;
	logic [7:0] sec_rdata = 8'h00;
	logic clock_lane_pos, clock_lane_neg, clock_lane_normal;
	logic [1:0] submap_select;
	int n_errors = 0;
	int num_checks = 0;
	assign sda = !(sda_pull || (sda_oe && !sda_out));
	i2c_host_model host (.scl(scl), .sda_pull(sda_pull), .sda(sda));
	video_decoder_user_submap_regs dut (.core_clk(core_clk), .srst(srst), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .lock_status_in(8'hc3),
		.signal_status_two_in(8'hff), .signal_status_three_in(8'haf),
		.sec_map_sel(sec_map_sel), .sec_wr_stb(sec_wr_stb), .sec_rd_stb(sec_rd_stb),
		.sec_offset(sec_offset), .sec_wdata(sec_wdata), .sec_rdata(sec_rdata),
		.clock_lane_pos(clock_lane_pos), .clock_lane_neg(clock_lane_neg),
		.clock_lane_normal(clock_lane_normal), .submap_select(submap_select));
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	// secondary map stand-in: data follows the offset
	always @(negedge core_clk) sec_rdata <= sec_offset ^ 8'h3c;
	always @(negedge core_clk) begin
		if (sec_wr_stb === 1'b1) begin
			wr_sel <= sec_map_sel;
			wr_ofs <= sec_offset;
			wr_dat <= sec_wdata;
		end
	end
	task automatic check(input string what, input logic [7:0] e, input logic [7:0] got);
		num_checks++;
		if (got !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, e, got);
		end
	endtask
	task automatic xw(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] d);
		logic a;
		host.start();
		host.wbyte({dev, 1'b0}, a);
		host.wbyte(ofs, a);
		host.wbyte(d, a);
		host.stop();
	endtask
	task automatic xr(input logic [6:0] dev, input logic [7:0] ofs, output logic [7:0] d);
		logic a;
		host.start();
		host.wbyte({dev, 1'b0}, a);
		host.wbyte(ofs, a);
		host.start();
		host.wbyte({dev, 1'b1}, a);
		host.rbyte(1'b1, d);
		host.stop();
	endtask
	task automatic probe(input logic [6:0] dev, output logic a);
		host.start();
		host.wbyte({dev, 1'b0}, a);
		host.stop();
	endtask
	task automatic lanes(input string what, input logic [2:0] e);
		int k;
		k = 0;
		while (k < 60 && {clock_lane_pos, clock_lane_neg, clock_lane_normal} !== e) begin
			@(negedge core_clk);
			k++;
		end
		check(what, {5'h00, e}, {5'h00, clock_lane_pos, clock_lane_neg, clock_lane_normal});
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (95000) @(posedge core_clk);
		n_errors++;
		conclude();
	end
	initial begin
		repeat (8) @(negedge core_clk);
		srst = 1'b0;
		repeat (4) @(negedge core_clk);
		for (int i = 0; i < RW_COUNT; i++) begin
			xr(UA, RW_OFS[i], rd);
			check("reset value", RW_RST[i], rd);
		end
		xr(UA, OFS_LOCK_STATUS_ONE, rd);
		check("status one", 8'hc3, rd);
		xr(UA, OFS_DEVICE_IDENT, rd);
		check("ident", IDENT_DEF, rd);
		xr(UA, OFS_SIGNAL_STATUS_TWO, rd);
		check("status two", 8'h3f, rd);
		xr(UA, OFS_SIGNAL_STATUS_THREE, rd);
		check("status three", 8'ha5, rd);
		lanes("reset lanes", 3'b111);
		$display("test reset done");
		probe(PA, ack);
		check("unset pp ack", 8'h00, {7'h00, ack});
		probe(TA, ack);
		check("unset tx ack", 8'h00, {7'h00, ack});
		for (int i = 0; i < RW_COUNT; i++) begin
			if (i != IDX_SUBMAP && i != IDX_ESC) begin
				xw(UA, RW_OFS[i], RW_RST[i] ^ 8'h5a);
				xr(UA, RW_OFS[i], rd);
				check("readback", (RW_RST[i] ^ 8'h5a) & RW_MASK[i], rd);
			end
		end
		$display("test read write done");
		for (int s = 1; s < 4; s++) begin
			xw(UA, OFS_SUBMAP_CONTROL, 8'(s << SUBMAP_SEL_LSB));
			check("select port", 8'(s), {6'h00, submap_select});
			xw(UA, 8'h08, 8'h11);
			xr(UA, 8'h08, rd);
			check("hidden read", 8'h00, rd);
		end
		xw(UA, OFS_SUBMAP_CONTROL, 8'h00);
		xr(UA, 8'h08, rd);
		check("write ignored", 8'hda, rd);
		$display("test submap done");
		xw(UA, 8'hfd, 8'h84);
		xw(UA, 8'hfe, 8'h88);
		xw(PA, 8'h05, 8'hc3);
		check("pp sel", 8'h00, {7'h00, wr_sel});
		check("pp offset", 8'h05, wr_ofs);
		check("pp data", 8'hc3, wr_dat);
		xw(TA, 8'h07, 8'h96);
		check("tx sel", 8'h01, {7'h00, wr_sel});
		check("tx data", 8'h96, wr_dat);
		xr(TA, 8'h07, rd);
		check("tx read", 8'h07 ^ 8'h3c, rd);
		xr(PA, 8'h05, rd);
		check("pp read", 8'h05 ^ 8'h3c, rd);
		probe(7'h43, ack);
		check("stray ack", 8'h00, {7'h00, ack});
		$display("test secondary done");
		xw(UA, OFS_ESCAPE_CONTROL, 8'h00);
		lanes("normal", 3'b111);
		xw(UA, OFS_ESCAPE_CONTROL, 8'h20);
		lanes("ulps", 3'b000);
		xr(UA, OFS_ESCAPE_CONTROL, rd);
		exp = 8'h00;
		exp[ESC_ENABLE_BIT] = 1'b1;
		check("ulps read", exp, rd);
		xw(UA, OFS_ESCAPE_CONTROL, 8'h10);
		lanes("ulps kept", 3'b000);
		xr(UA, OFS_ESCAPE_CONTROL, rd);
		check("ulps read forced", exp, rd);
		xw(UA, OFS_ESCAPE_CONTROL, 8'h30);
		lanes("exit high", 3'b110);
		xw(UA, OFS_ESCAPE_CONTROL, 8'h10);
		lanes("normal op", 3'b111);
		xw(UA, OFS_ESCAPE_CONTROL, 8'h00);
		lanes("unchanged", 3'b111);
		$display("test lanes done");
		conclude();
	end
endmodule
